// ---- logic/pwm_pkg.sv ----
package pwm_pkg;

  // ****************************************************************
  // Register offsets
  // ****************************************************************
  localparam logic [7:0] ADDR_CLK     = 8'h40;
  localparam logic [7:0] ADDR_POL     = 8'h41;
  localparam logic [7:0] ADDR_EN      = 8'h42;
  localparam logic [7:0] ADDR_PRES    = 8'h43;
  localparam logic [7:0] ADDR_SCAL0   = 8'h44;
  localparam logic [7:0] ADDR_SCNT0   = 8'h45;
  localparam logic [7:0] ADDR_SCAL1   = 8'h46;
  localparam logic [7:0] ADDR_SCNT1   = 8'h47;
  localparam logic [7:0] ADDR_CNT0    = 8'h48;
  localparam logic [7:0] ADDR_PER0    = 8'h4C;
  localparam logic [7:0] ADDR_DUTY0   = 8'h50;
  localparam logic [7:0] ADDR_CENTER  = 8'h54;

  // ****************************************************************
  // Field positions
  // ****************************************************************
  localparam int UPPER_JOIN_BIT  = 7;
  localparam int LOWER_JOIN_BIT  = 6;
  localparam int CLK_A_SEL_LSB   = 3;
  localparam int CLK_B_SEL_LSB   = 0;
  localparam int CLOCK_CHOICE_LSB = 4;
  localparam int START_LEVEL_LSB = 0;
  localparam int PRES_W          = 7;

  // ****************************************************************
  // Reset values
  // ****************************************************************
  localparam logic [7:0] CLK_RESET    = 8'h00;
  localparam logic [7:0] POL_RESET    = 8'h00;
  localparam logic [3:0] EN_RESET     = 4'h0;
  localparam logic [3:0] CENTER_RESET = 4'h0;
  localparam logic [7:0] SCAL_RESET   = 8'h00;
  localparam logic [7:0] CNT_RESET    = 8'h00;
  localparam logic [7:0] PER_RESET    = 8'hFF;
  localparam logic [7:0] DUTY_RESET   = 8'hFF;

  typedef enum logic [1:0] {
    DIR_UP   = 2'b01,
    DIR_DOWN = 2'b10
  } count_dir_t;

  // Prescaler tap: true when the low sel bits of the counter are all ones
  function automatic logic prescale_tick(input logic [PRES_W-1:0] cnt,
                                         input logic [2:0]        sel);
    logic [PRES_W-1:0] mask;
    mask = PRES_W'((8'h01 << sel) - 8'h01);
    return &(cnt | ~mask);
  endfunction

endpackage

// ---- logic/pwm_prescaler.sv ----
module pwm_prescaler
  import pwm_pkg::*;
(
  // Clock and reset
  input  wire logic              mclk_i,
  input  wire logic              resetn_i,
  // Control
  input  wire logic              run_i,
  input  wire logic [2:0]        sel_a_i,
  input  wire logic [2:0]        sel_b_i,
  // Status
  output logic [PRES_W-1:0]      cnt_o,
  output logic                   tick_a_o,
  output logic                   tick_b_o
);

  // Free-running divider, held while every channel is off
  always_ff @(posedge mclk_i) begin
    if (!resetn_i) begin
      cnt_o <= '0;
    end else if (run_i) begin
      cnt_o <= cnt_o + 1'b1;
    end
  end

  assign tick_a_o = run_i && prescale_tick(cnt_o, sel_a_i);
  assign tick_b_o = run_i && prescale_tick(cnt_o, sel_b_i);

endmodule

// ---- logic/pwm_scaler.sv ----
module pwm_scaler
  import pwm_pkg::*;
(
  // Clock and reset
  input  wire logic       mclk_i,
  input  wire logic       resetn_i,
  // Control
  input  wire logic       tick_i,
  input  wire logic [7:0] scal_i,
  input  wire logic       load_i,
  input  wire logic [7:0] load_val_i,
  // Status
  output logic [7:0]      cnt_o,
  output logic            tick_o
);

  logic half;

  // Down counter reloads every scal+1 input ticks; output every second reload
  always_ff @(posedge mclk_i) begin
    if (!resetn_i) begin
      cnt_o <= CNT_RESET;
      half  <= 1'b0;
    end else if (load_i) begin
      cnt_o <= load_val_i;
    end else if (tick_i) begin
      if (cnt_o == 8'h00) begin
        cnt_o <= scal_i;
        half  <= ~half;
      end else begin
        cnt_o <= cnt_o - 8'h01;
      end
    end
  end

  assign tick_o = tick_i && !load_i && (cnt_o == 8'h00) && half;

endmodule

// ---- logic/four_channel_pwm.sv ----
// How it works
// - Four 8-bit channels, pairable to 16-bit
// - Duty programmable from 0 to 100 percent
// - Left- or center-aligned per channel
// - Enabled: new values wait for rollover/disable
// - Disabled: writes reach active latch immediately
// - Counter write clears count, loads buffers
// - Channel counters readable by software
// - Enabled channel owns pin over port; a joined pair, enabled by its low channel's bit, drives the high channel's pin
// - Upper pair joined: ch2 high, ch3 low
// - Lower pair joined: ch0 high, ch1 low
// - Clock A is P over 2^field
// - Clock B is P over 2^field
// - Ch2/3 select: 0 clock B, 1 S1
// - Ch0/1 select: 0 clock A, 1 S0
// - Select change may glitch one pulse
// - Start level bit, left-aligned only
// - S0/S1 = A/B over (scale+1) twice
// - Enable forces pin output, keeps direction
// - Left-aligned period match restarts counter
// - Center-aligned counter reverses at period
//
// The implementer's own choice: the strobed register port.
module four_channel_pwm
  import pwm_pkg::*;
(
  // Clock and reset
  input  wire logic       mclk_i,
  input  wire logic       resetn_i,
  // Register port
  input  wire logic [7:0] addr_i,
  input  wire logic [7:0] wdata_i,
  input  wire logic       wr_i,
  input  wire logic       rd_i,
  output logic [7:0]      rdata_o,
  // Shared port pins
  input  wire logic [3:0] port_dir_i,
  input  wire logic [3:0] port_data_i,
  output logic [3:0]      pin_o,
  output logic [3:0]      pin_oe_n_o
);

  // ****************************************************************
  // Registers
  // ****************************************************************
  logic [7:0]        clk_reg;
  logic [7:0]        pol_reg;
  logic [3:0]        en_reg;
  logic [3:0]        center_reg;
  logic [7:0]        scal [2];
  logic [7:0]        cnt [4];
  logic [7:0]        per_buf [4];
  logic [7:0]        per_act [4];
  logic [7:0]        duty_buf [4];
  logic [7:0]        duty_act [4];
  count_dir_t        dir [4];

  logic [PRES_W-1:0] pres_cnt;
  logic              tick_a;
  logic              tick_b;
  logic [7:0]        scnt [2];
  logic [1:0]        s_tick;

  logic [1:0]        join_pair;
  logic [3:0]        wr_cnt;
  logic [3:0]        wr_per;
  logic [3:0]        wr_duty;
  logic [3:0]        cnt_clr;
  logic [3:0]        en_eff;
  logic [3:0]        tick_ch;
  logic [3:0]        step;
  logic [3:0]        roll;
  logic [3:0]        level;
  logic [3:0]        pwm_on;
  logic [15:0]       next_cnt [4];
  count_dir_t        next_dir [4];
  logic [7:0]        next_per_buf [4];
  logic [7:0]        next_duty_buf [4];

  // Controlling channel: in a joined pair the low-order channel rules
  function automatic int ctl_ch(input int i, input logic [1:0] jn);
    return jn[i/2] ? (i | 1) : i;
  endfunction

  // ****************************************************************
  // Clock sources
  // ****************************************************************
  assign join_pair = {clk_reg[UPPER_JOIN_BIT], clk_reg[LOWER_JOIN_BIT]};

  pwm_prescaler u_pres (
    .mclk_i   (mclk_i),
    .resetn_i (resetn_i),
    .run_i    (|en_reg),
    .sel_a_i  (clk_reg[CLK_A_SEL_LSB +: 3]),
    .sel_b_i  (clk_reg[CLK_B_SEL_LSB +: 3]),
    .cnt_o    (pres_cnt),
    .tick_a_o (tick_a),
    .tick_b_o (tick_b)
  );

  pwm_scaler u_scal0 (
    .mclk_i     (mclk_i),
    .resetn_i   (resetn_i),
    .tick_i     (tick_a),
    .scal_i     (scal[0]),
    .load_i     (wr_i && addr_i == ADDR_SCAL0),
    .load_val_i (wdata_i),
    .cnt_o      (scnt[0]),
    .tick_o     (s_tick[0])
  );

  pwm_scaler u_scal1 (
    .mclk_i     (mclk_i),
    .resetn_i   (resetn_i),
    .tick_i     (tick_b),
    .scal_i     (scal[1]),
    .load_i     (wr_i && addr_i == ADDR_SCAL1),
    .load_val_i (wdata_i),
    .cnt_o      (scnt[1]),
    .tick_o     (s_tick[1])
  );

  // ****************************************************************
  // Channel step logic
  // ****************************************************************
  always_comb begin
    for (int i = 0; i < 4; i++) begin
      automatic int c    = ctl_ch(i, join_pair);
      automatic int hi   = (i / 2) * 2;
      automatic int lo   = hi + 1;
      automatic logic [15:0] cw = 16'h0000;
      automatic logic [15:0] pw = 16'h0000;
      automatic logic [15:0] dw = 16'h0000;
      wr_cnt[i]  = wr_i && addr_i == ADDR_CNT0 + 8'(i);
      wr_per[i]  = wr_i && addr_i == ADDR_PER0 + 8'(i);
      wr_duty[i] = wr_i && addr_i == ADDR_DUTY0 + 8'(i);
      next_per_buf[i]  = wr_per[i] ? wdata_i : per_buf[i];
      next_duty_buf[i] = wr_duty[i] ? wdata_i : duty_buf[i];
      en_eff[i] = en_reg[c];
      // Switching the select mid-waveform can clip or stretch one pulse
      tick_ch[i] = pol_reg[CLOCK_CHOICE_LSB + c] ? s_tick[i/2] :
                   ((i < 2) ? tick_a : tick_b);
      step[i] = en_eff[i] && tick_ch[i];
      if (join_pair[i/2]) begin
        cw = {cnt[hi], cnt[lo]};
        pw = {per_act[hi], per_act[lo]};
        dw = {duty_act[hi], duty_act[lo]};
      end else begin
        cw = {8'h00, cnt[i]};
        pw = {8'h00, per_act[i]};
        dw = {8'h00, duty_act[i]};
      end
      roll[i]     = 1'b0;
      next_dir[i] = dir[c];
      next_cnt[i] = cw + 16'h0001;
      if (!center_reg[c]) begin
        next_dir[i] = DIR_UP;
        if ({1'b0, cw} + 17'h00001 >= {1'b0, pw}) begin
          next_cnt[i] = 16'h0000;
          roll[i]     = 1'b1;
        end
        level[i] = (cw < dw) ? pol_reg[START_LEVEL_LSB + c] :
                               ~pol_reg[START_LEVEL_LSB + c];
      end else begin
        case (dir[c])
          DIR_UP: begin
            if (cw >= pw) begin
              next_dir[i] = DIR_DOWN;
              next_cnt[i] = (cw == 16'h0000) ? 16'h0000 : cw - 16'h0001;
            end
          end
          DIR_DOWN: begin
            if (cw == 16'h0000) begin
              next_dir[i] = DIR_UP;
              next_cnt[i] = (pw == 16'h0000) ? 16'h0000 : 16'h0001;
              roll[i]     = 1'b1;
            end else begin
              next_cnt[i] = cw - 16'h0001;
            end
          end
          default: begin
            next_dir[i] = DIR_UP;
            next_cnt[i] = 16'h0000;
          end
        endcase
        level[i] = (cw < dw) ? 1'b0 : 1'b1;
      end
      cnt_clr[i] = wr_cnt[i] || (join_pair[i/2] && wr_i &&
                   (addr_i == ADDR_CNT0 + 8'(hi) || addr_i == ADDR_CNT0 + 8'(lo)));
      pwm_on[i]  = en_eff[i] && !(join_pair[i/2] && i == lo);
    end
  end

  // ****************************************************************
  // Counters
  // ****************************************************************
  always_ff @(posedge mclk_i) begin
    for (int i = 0; i < 4; i++) begin
      if (!resetn_i) begin
        cnt[i] <= CNT_RESET;
        dir[i] <= DIR_UP;
      end else if (cnt_clr[i]) begin
        cnt[i] <= CNT_RESET;
        dir[i] <= DIR_UP;
      end else if (step[i]) begin
        cnt[i] <= (join_pair[i/2] && (i % 2 == 0)) ? next_cnt[i][15:8] :
                                                     next_cnt[i][7:0];
        dir[i] <= next_dir[i];
      end
    end
  end

  // ****************************************************************
  // Period and duty double buffers
  // ****************************************************************
  always_ff @(posedge mclk_i) begin
    for (int i = 0; i < 4; i++) begin
      if (!resetn_i) begin
        per_buf[i]  <= PER_RESET;
        per_act[i]  <= PER_RESET;
        duty_buf[i] <= DUTY_RESET;
        duty_act[i] <= DUTY_RESET;
      end else begin
        per_buf[i]  <= next_per_buf[i];
        duty_buf[i] <= next_duty_buf[i];
        if (!en_eff[i] || cnt_clr[i] || (step[i] && roll[i])) begin
          per_act[i]  <= next_per_buf[i];
          duty_act[i] <= next_duty_buf[i];
        end
      end
    end
  end

  // ****************************************************************
  // Configuration registers
  // ****************************************************************
  always_ff @(posedge mclk_i) begin
    if (!resetn_i) begin
      clk_reg    <= CLK_RESET;
      pol_reg    <= POL_RESET;
      en_reg     <= EN_RESET;
      center_reg <= CENTER_RESET;
      scal[0]    <= SCAL_RESET;
      scal[1]    <= SCAL_RESET;
    end else if (wr_i) begin
      case (addr_i)
        ADDR_CLK:    clk_reg    <= wdata_i;
        ADDR_POL:    pol_reg    <= wdata_i;
        ADDR_EN:     en_reg     <= wdata_i[3:0];
        ADDR_CENTER: center_reg <= wdata_i[3:0];
        ADDR_SCAL0:  scal[0]    <= wdata_i;
        ADDR_SCAL1:  scal[1]    <= wdata_i;
        default:     clk_reg    <= clk_reg;
      endcase
    end
  end

  // ****************************************************************
  // Read port
  // ****************************************************************
  always_ff @(posedge mclk_i) begin
    if (!resetn_i) begin
      rdata_o <= 8'h00;
    end else if (rd_i) begin
      case (addr_i)
        ADDR_CLK:           rdata_o <= clk_reg;
        ADDR_POL:           rdata_o <= pol_reg;
        ADDR_EN:            rdata_o <= {4'h0, en_reg};
        ADDR_PRES:          rdata_o <= {1'b0, pres_cnt};
        ADDR_SCAL0:         rdata_o <= scal[0];
        ADDR_SCNT0:         rdata_o <= scnt[0];
        ADDR_SCAL1:         rdata_o <= scal[1];
        ADDR_SCNT1:         rdata_o <= scnt[1];
        ADDR_CNT0 + 8'h00:  rdata_o <= cnt[0];
        ADDR_CNT0 + 8'h01:  rdata_o <= cnt[1];
        ADDR_CNT0 + 8'h02:  rdata_o <= cnt[2];
        ADDR_CNT0 + 8'h03:  rdata_o <= cnt[3];
        ADDR_PER0 + 8'h00:  rdata_o <= per_buf[0];
        ADDR_PER0 + 8'h01:  rdata_o <= per_buf[1];
        ADDR_PER0 + 8'h02:  rdata_o <= per_buf[2];
        ADDR_PER0 + 8'h03:  rdata_o <= per_buf[3];
        ADDR_DUTY0 + 8'h00: rdata_o <= duty_buf[0];
        ADDR_DUTY0 + 8'h01: rdata_o <= duty_buf[1];
        ADDR_DUTY0 + 8'h02: rdata_o <= duty_buf[2];
        ADDR_DUTY0 + 8'h03: rdata_o <= duty_buf[3];
        ADDR_CENTER:        rdata_o <= {4'h0, center_reg};
        default:            rdata_o <= 8'h00;
      endcase
    end else begin
      rdata_o <= 8'h00;
    end
  end

  // ****************************************************************
  // Pin sharing
  // ****************************************************************
  always_ff @(posedge mclk_i) begin
    if (!resetn_i) begin
      pin_o      <= 4'h0;
      pin_oe_n_o <= 4'hF;
    end else begin
      for (int i = 0; i < 4; i++) begin
        pin_o[i]      <= pwm_on[i] ? level[i] : port_data_i[i];
        pin_oe_n_o[i] <= ~(pwm_on[i] | port_dir_i[i]);
      end
    end
  end

  // ****************************************************************
  // Assertions
  // ****************************************************************
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (!resetn_i);

  sequence cnt_write_s(int k);
    wr_i && addr_i == ADDR_CNT0 + 8'(k) && !join_pair[k/2];
  endsequence

  sequence cleared_s(int k);
    cnt[k] == 8'h00 && per_act[k] == per_buf[k] && duty_act[k] == duty_buf[k];
  endsequence

  for (genvar g = 0; g < 4; g++) begin : g_chk
    AST_CNT_WRITE_LOADS: assert property (
      cnt_write_s(g) |=> cleared_s(g))
      else $error("counter write did not clear and load");

    AST_DISABLED_DIRECT: assert property (
      wr_i && addr_i == ADDR_PER0 + 8'(g) && !en_eff[g] |=> per_act[g] == $past(wdata_i))
      else $error("disabled period write missed active latch");

    AST_ENABLED_HOLDS: assert property (
      en_eff[g] && !cnt_clr[g] && !(step[g] && roll[g]) |=> $stable(per_act[g]))
      else $error("active period changed mid-period");

    AST_PIN_OWNED: assert property (
      pwm_on[g] |=> !pin_oe_n_o[g] && pin_o[g] == $past(level[g]))
      else $error("enabled channel does not drive its pin");

    AST_PIN_GENERAL: assert property (
      !pwm_on[g] |=> pin_oe_n_o[g] == !$past(port_dir_i[g]) && pin_o[g] == $past(port_data_i[g]))
      else $error("idle pin not under port control");

    AST_LEFT_ROLL: assert property (
      step[g] && !center_reg[g] && !join_pair[g/2] && !cnt_clr[g]
      && {1'b0, cnt[g]} + 9'h001 >= {1'b0, per_act[g]} |=> cnt[g] == 8'h00)
      else $error("left-aligned counter missed period match");
  end

  AST_CNT_READ: assert property (
    rd_i && addr_i == ADDR_CNT0 |=> rdata_o == $past(cnt[0]))
    else $error("counter read returned wrong value");

  AST_CLOCK_A_FULL: assert property (
    (|en_reg) && clk_reg[CLK_A_SEL_LSB +: 3] == 3'h0 |-> tick_a)
    else $error("clock A not undivided at code zero");

  AST_CLOCK_B_HALF: assert property (
    tick_b && clk_reg[CLK_B_SEL_LSB +: 3] == 3'h1 && !wr_i |=> !tick_b)
    else $error("clock B half rate ticked twice in a row");

  AST_POL_WRITE_READ: assert property (
    wr_i && addr_i == ADDR_POL ##1 !wr_i ##1 rd_i && addr_i == ADDR_POL && !wr_i
    |=> rdata_o == $past(wdata_i, 3))
    else $error("select and polarity register did not read back");

endmodule

// ---- verification/pin_load_model.sv ----
module pin_load_model (
  // Block side
  input  wire logic [3:0] pin_i,
  input  wire logic [3:0] oe_n_i,
  // Port side
  input  wire logic [3:0] dir_i,
  input  wire logic [3:0] data_i,
  // Resolved pad level
  output logic [3:0]      pad_o
);
  timeunit 1ns;
  timeprecision 1ns;

  // ****************************************************************
  // Pad resolution, pull-up when nobody drives
  // ****************************************************************
  always_comb begin
    for (int i = 0; i < 4; i++) begin
      if (oe_n_i[i] == 1'b0) begin
        pad_o[i] = pin_i[i];
      end else if (dir_i[i] == 1'b1) begin
        pad_o[i] = data_i[i];
      end else begin
        pad_o[i] = 1'b1;
      end
    end
  end
endmodule

// ---- verification/four_channel_pwm_test.sv ----
module four_channel_pwm_test import pwm_pkg::*; ;
  timeunit 1ns;
  timeprecision 1ns;

  logic       mclk_i;
  logic       resetn_i;
  logic [7:0] addr_i;
  logic [7:0] wdata_i;
  logic       wr_i;
  logic       rd_i;
  logic [7:0] rdata_o;
  logic [3:0] port_dir_i;
  logic [3:0] port_data_i;
  logic [3:0] pin_o;
  logic [3:0] pin_oe_n_o;
  logic [3:0] pad;
  int         error_cnt;
  int         comparisons;
  int         seed;
  logic [7:0] exp_q [$];

  localparam logic [7:0] RST_ADDR [7] = '{ADDR_CLK, ADDR_POL, ADDR_EN, ADDR_PER0, ADDR_DUTY0,
                                          ADDR_CNT0, 8'h60};
  localparam logic [7:0] RST_VAL  [7] = '{CLK_RESET, POL_RESET, 8'h00, PER_RESET, DUTY_RESET,
                                          CNT_RESET, 8'h00};

  four_channel_pwm u_dut (
    .mclk_i      (mclk_i),
    .resetn_i    (resetn_i),
    .addr_i      (addr_i),
    .wdata_i     (wdata_i),
    .wr_i        (wr_i),
    .rd_i        (rd_i),
    .rdata_o     (rdata_o),
    .port_dir_i  (port_dir_i),
    .port_data_i (port_data_i),
    .pin_o       (pin_o),
    .pin_oe_n_o  (pin_oe_n_o)
  );

  pin_load_model u_load (
    .pin_i  (pin_o),
    .oe_n_i (pin_oe_n_o),
    .dir_i  (port_dir_i),
    .data_i (port_data_i),
    .pad_o  (pad)
  );

  initial begin
    mclk_i = 1'b0;
    forever #50 mclk_i = ~mclk_i;
  end

  // ****************************************************************
  // Bench tasks
  // ****************************************************************
  task automatic give_verdict;
    $display("errors %0d comparisons %0d", error_cnt, comparisons);
    if (error_cnt == 0 && comparisons > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
    comparisons++;
    if (seen !== exp) begin
      error_cnt++;
      $display("[ERR] %s expected %0h seen %0h", nm, exp, seen);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge mclk_i);
    addr_i  <= a;
    wdata_i <= d;
    wr_i    <= 1'b1;
    @(posedge mclk_i);
    wr_i    <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge mclk_i);
    addr_i <= a;
    rd_i   <= 1'b1;
    @(posedge mclk_i);
    rd_i   <= 1'b0;
    @(negedge mclk_i);
    d = rdata_o;
  endtask

  // Runs one channel and counts cycles at its start level over two periods
  task automatic wave(input int ch, code, input bit s, input int scal, per, duty,
                      input bit pol, ctr, input int pair_mode);
    int         ctl;
    int         pin;
    int         t;
    int         w;
    int         n;
    int         ex;
    logic [7:0] cv;
    ctl = (pair_mode != 0) ? (ch | 1) : ch;
    pin = (pair_mode != 0) ? (ch & 2) : ch;
    t   = (1 << code) * (s ? 2 * (scal + 1) : 1);
    w   = ctr ? 4 * per * t : 2 * per * t;
    ex  = ctr ? 2 * (2 * duty - 1) * t : 2 * ((duty < per) ? duty : per) * t;
    wr(ADDR_EN, 8'h00);
    wr(ADDR_CLK, 8'((pair_mode == 2 ? 128 : 0) + (pair_mode == 1 ? 64 : 0) + code * 9));
    wr(ADDR_POL, 8'((int'(s) << (4 + ctl)) | (int'(pol) << ctl)));
    wr(ADDR_SCAL0, 8'(scal));
    wr(ADDR_SCAL1, 8'(scal));
    if (pair_mode != 0) begin
      wr(ADDR_PER0 + 8'(pin), 8'h00);
      wr(ADDR_DUTY0 + 8'(pin), 8'h00);
    end
    wr(ADDR_PER0 + 8'(ctl), 8'(per));
    wr(ADDR_DUTY0 + 8'(ctl), 8'(duty));
    wr(ADDR_CENTER, ctr ? 8'(1 << ctl) : 8'h00);
    wr(ADDR_CNT0 + 8'(ctl), 8'h00);
    wr(ADDR_EN, 8'(1 << ctl));
    repeat (w + 40) @(posedge mclk_i);
    n = 0;
    repeat (w) begin
      @(negedge mclk_i);
      if (pad[pin] === (ctr ? 1'b0 : pol)) n++;
    end
    chk("start level cycles", 16'(n), 16'(ex));
    chk("pwm pin enable", 16'(pin_oe_n_o[pin]), 16'h0000);
    if (pair_mode != 0) chk("freed pin enable", 16'(pin_oe_n_o[pin + 1]), 16'h0001);
    rd(ADDR_CNT0 + 8'(ctl), cv);
    chk("running count in range", 16'(cv <= 8'(per)), 16'h0001);
    wr(ADDR_EN, 8'h00);
    wr(ADDR_CNT0 + 8'(ctl), 8'h00);
    rd(ADDR_CNT0 + 8'(ctl), cv);
    chk("count after write", 16'(cv), 16'h0000);
  endtask

  initial begin
    repeat (100000) @(posedge mclk_i);
    error_cnt++;
    $display("[ERR] run time limit expected end seen hang");
    give_verdict();
  end

  // ****************************************************************
  // Main sequence
  // ****************************************************************
  initial begin
    logic [7:0] v;
    logic [7:0] d;
    seed        = 58262;
    error_cnt   = 0;
    comparisons = 0;
    resetn_i    = 1'b0;
    addr_i      = 8'h00;
    wdata_i     = 8'h00;
    wr_i        = 1'b0;
    rd_i        = 1'b0;
    port_dir_i  = 4'h0;
    port_data_i = 4'h0;
    repeat (5) @(posedge mclk_i);
    resetn_i <= 1'b1;
    for (int i = 0; i < 7; i++) begin
      rd(RST_ADDR[i], d);
      chk("reset value", 16'(d), 16'(RST_VAL[i]));
    end
    for (int i = 0; i < 4; i++) begin
      v = 8'($random(seed));
      wr(ADDR_POL, v);
      exp_q.push_back(v);
      rd(ADDR_POL, d);
      chk("select and level reg", 16'(d), 16'(exp_q.pop_front()));
      v = 8'($random(seed));
      wr(ADDR_CLK, v);
      exp_q.push_back(v);
      rd(ADDR_CLK, d);
      chk("prescale and join reg", 16'(d), 16'(exp_q.pop_front()));
    end
    wr(ADDR_CLK, 8'h00);
    wr(ADDR_POL, 8'h00);
    for (int i = 0; i < 6; i++) begin
      @(posedge mclk_i);
      port_dir_i  <= 4'($random(seed));
      port_data_i <= 4'($random(seed));
      repeat (2) @(posedge mclk_i);
      @(negedge mclk_i);
      chk("port enable", 16'(pin_oe_n_o), {12'h000, ~port_dir_i});
      chk("port data", 16'(pin_o), 16'(port_data_i));
      chk("pad level", 16'(pad), {12'h000, (port_dir_i & port_data_i) | ~port_dir_i});
    end
    @(posedge mclk_i);
    port_dir_i <= 4'h0;
    for (int c = 0; c < 8; c++) begin
      wave(0, c, 1'b0, 0, 2, 1, 1'b0, 1'b0, 0);
      wave(2, c, 1'b0, 0, 2, 1, 1'b1, 1'b0, 0);
    end
    wave(1, 1, 1'b0, 0, 4, 3, 1'b1, 1'b0, 0);
    wave(2, 2, 1'b0, 0, 3, 0, 1'b0, 1'b0, 0);
    wave(3, 0, 1'b0, 0, 3, 5, 1'b1, 1'b0, 0);
    wave(1, 0, 1'b1, 1, 3, 1, 1'b0, 1'b0, 0);
    wave(0, 0, 1'b1, 0, 3, 1, 1'b1, 1'b0, 0);
    wave(3, 1, 1'b1, 0, 3, 1, 1'b1, 1'b0, 0);
    wave(2, 0, 1'b1, 2, 3, 2, 1'b0, 1'b0, 0);
    wave(2, 0, 1'b0, 0, 4, 2, 1'b0, 1'b1, 0);
    wave(0, 0, 1'b0, 0, 5, 2, 1'b0, 1'b0, 1);
    wave(2, 3, 1'b0, 0, 3, 1, 1'b0, 1'b0, 2);
    give_verdict();
  end
endmodule
